// file: psf_pkg.sv
/*
  Constants for the port isolation and MAC limit filter: register map,
  field positions, reset values and limits.
  Assumes a 32-bit AHB-Lite register bus and nine switch ports, 0 being the CPU port.
*/
`default_nettype none
package psf_pkg;
  // ----------------------------------------
  // Ports
  // ----------------------------------------
  localparam int NPORT = 9;
  typedef logic [8:0] psf_mask_t;
  typedef logic [9:0] psf_cnt_t;
  localparam logic [3:0] CPU_PORT = 4'h0;
  localparam logic [3:0] LAST_PORT = 4'h8;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RANGE = 8'h04;
  localparam logic [7:0] OFF_SEC_EN = 8'h08;
  localparam logic [7:0] OFF_FULL = 8'h0c;
  localparam logic [7:0] OFF_ISO_BASE = 8'h20;
  localparam logic [7:0] OFF_MAX_BASE = 8'h60;
  // ----------------------------------------
  // Fields
  // ----------------------------------------
  localparam int CTRL_GLOB_BIT = 0;
  localparam int RNG_LO_LSB = 0;
  localparam int RNG_HI_LSB = 4;
  localparam int RNG_EN_VAL_BIT = 8;
  localparam int RNG_EN_APPLY_BIT = 9;
  localparam int RNG_MAX_LSB = 16;
  localparam int RNG_MAX_APPLY_BIT = 26;
  localparam int MAX_CNT_LSB = 16;
  // ----------------------------------------
  // Reset values and limits
  // ----------------------------------------
  localparam psf_cnt_t MAX_MAC_RESET = 10'h005;
  localparam psf_cnt_t MAX_MAC_MIN = 10'h001;
  localparam psf_cnt_t MAX_MAC_LIMIT = 10'h3e8;
  localparam psf_mask_t ISO_ALL = 9'h1ff;
  // Bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WR = 2'b01,
    BUS_RD = 2'b10
  } psf_bus_e;
endpackage : psf_pkg
`default_nettype wire

// file: psf_mac_counter.sv
/*
  Per-port count of MAC addresses in use, learned and static alike.
  Assumes the caller gates the full flag with the port-security enables.
*/
`timescale 1ns/10ps
`default_nettype none
module psf_mac_counter (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Events
  input wire logic inc_learn,
  input wire logic inc_static,
  input wire logic dec_age,
  input wire logic clear,
  // Limit
  input wire psf_pkg::psf_cnt_t max_mac,
  output logic full,
  output psf_pkg::psf_cnt_t count
);
  logic [11:0] next_count;

  always_comb begin
    next_count = {2'b00, count} + {11'h000, inc_learn} + {11'h000, inc_static};
    if (dec_age && next_count != 12'h000) begin
      next_count = next_count - 12'h001;
    end
    if (next_count > 12'h3ff) begin
      next_count = 12'h3ff;
    end
  end

  // Flush beats any simultaneous learn: the port just came up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else begin
      count <= next_count[9:0];
    end
  end

  assign full = (count >= max_mac);

  a_clear_empties: assert property (@(posedge hclk) disable iff (!hresetn)
    clear |=> count == 10'h000) else $error("flush left MAC count nonzero");
  a_static_counts: assert property (@(posedge hclk) disable iff (!hresetn)
    inc_static && !inc_learn && !dec_age && !clear && count < 10'h3ff |=> count == $past(count) + 10'h001)
    else $error("static MAC not counted");
endmodule : psf_mac_counter
`default_nettype wire

// file: psf_filter.sv
/*
  Port isolation and MAC limit filter with an AHB-Lite register slave.
  Assumes one switch core clock, a forwarding engine that presents one
  lookup per request with the source-MAC hit already resolved, and nine ports.
*/
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module psf_filter (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Lookup request from the forwarding engine
  input wire logic req_valid,
  input wire logic [3:0] req_port,
  input wire logic req_src_known,
  input wire psf_pkg::psf_mask_t req_dst_mask,
  // Filter decision
  output logic dec_valid,
  output logic [3:0] dec_port,
  output psf_pkg::psf_mask_t dec_egress,
  output logic dec_drop,
  output logic dec_learn,
  // Address table events
  input wire logic static_add_valid,
  input wire logic [3:0] static_port,
  input wire logic age_valid,
  input wire logic [3:0] age_port,
  input wire logic [8:1] link_up,
  output logic [8:1] flush_mask
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic psf_pkg::psf_mask_t port_bit(input logic [3:0] p);
    port_bit = (p <= psf_pkg::LAST_PORT) ? psf_pkg::psf_mask_t'(9'h001 << p) : '0;
  endfunction : port_bit

  // Index of a word within a table at base, 5'h1f when outside it
  function automatic logic [4:0] tbl_idx(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    tbl_idx = (a >= base && d[1:0] == 2'b00 && d[7:2] <= 6'h08) ? d[6:2] : 5'h1f;
  endfunction : tbl_idx

  function automatic logic max_ok(input logic [9:0] v);
    max_ok = v >= psf_pkg::MAX_MAC_MIN && v <= psf_pkg::MAX_MAC_LIMIT;
  endfunction : max_ok

  // ----------------------------------------
  // State
  // ----------------------------------------
  psf_pkg::psf_bus_e bus_st;
  logic [7:0] addr_q;
  logic glob_en;
  logic [8:1] sec_en;
  psf_pkg::psf_mask_t iso_mask [0:8];
  psf_pkg::psf_cnt_t max_mac [1:8];
  psf_pkg::psf_cnt_t mac_cnt [1:8];
  logic [8:1] port_full;
  logic [8:1] link_q;
  logic [8:1] link_rise;
  logic [8:1] learn_inc;
  logic [8:1] static_inc;
  logic [8:1] age_dec;
  logic take;
  logic wr_now;
  logic [4:0] iso_i;
  logic [4:0] max_i;
  logic [3:0] rng_lo;
  logic [3:0] rng_hi;
  logic [9:0] rng_max;
  logic req_secured;
  logic drop_now;

  // ----------------------------------------
  // AHB-Lite slave: writes take no wait, reads one
  // ----------------------------------------
  // The read wait lets a write just before a read land before the mux samples
  assign take = hsel && hready && htrans[1];
  assign wr_now = bus_st == psf_pkg::BUS_WR;
  assign iso_i = tbl_idx(addr_q, psf_pkg::OFF_ISO_BASE);
  assign max_i = tbl_idx(addr_q, psf_pkg::OFF_MAX_BASE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st <= psf_pkg::BUS_IDLE;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (bus_st == psf_pkg::BUS_RD) begin
        bus_st <= psf_pkg::BUS_IDLE;
        hreadyout <= 1'b1;
      end else if (take) begin
        bus_st <= hwrite ? psf_pkg::BUS_WR : psf_pkg::BUS_RD;
        // Any address above the first 256 bytes lands on an unmapped word, never on a table
        addr_q <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hfc;
        hreadyout <= hwrite;
      end else begin
        bus_st <= psf_pkg::BUS_IDLE;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_st == psf_pkg::BUS_RD) begin
      hrdata <= 32'h0000_0000;
      if (addr_q == psf_pkg::OFF_CTRL) begin
        hrdata[psf_pkg::CTRL_GLOB_BIT] <= glob_en;
      end else if (addr_q == psf_pkg::OFF_SEC_EN) begin
        hrdata[8:1] <= sec_en;
      end else if (addr_q == psf_pkg::OFF_FULL) begin
        hrdata[8:1] <= port_full & sec_en & {8{glob_en}};
      end else if (iso_i != 5'h1f) begin
        hrdata[8:0] <= iso_mask[iso_i[3:0]];
      end else if (max_i != 5'h1f && max_i != 5'h00) begin
        hrdata[9:0] <= max_mac[max_i[3:0]];
        hrdata[psf_pkg::MAX_CNT_LSB +: 10] <= mac_cnt[max_i[3:0]];
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  assign rng_lo = hwdata[psf_pkg::RNG_LO_LSB +: 4];
  assign rng_hi = hwdata[psf_pkg::RNG_HI_LSB +: 4];
  assign rng_max = hwdata[psf_pkg::RNG_MAX_LSB +: 10];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      glob_en <= 1'b0;
    end else if (wr_now && addr_q == psf_pkg::OFF_CTRL) begin
      glob_en <= hwdata[psf_pkg::CTRL_GLOB_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p <= 8; p++) begin
        iso_mask[p] <= psf_pkg::ISO_ALL & ~port_bit(4'(p));
      end
    end else if (wr_now && iso_i != 5'h1f) begin
      iso_mask[iso_i[3:0]] <= hwdata[8:0];
    end
  end

  // Security enable and maximum, singly or over an inclusive port range
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_en <= 8'h00;
      for (int p = 1; p <= 8; p++) begin
        max_mac[p] <= psf_pkg::MAX_MAC_RESET;
      end
    end else if (wr_now) begin
      if (addr_q == psf_pkg::OFF_SEC_EN) begin
        sec_en <= hwdata[8:1];
      end else if (addr_q == psf_pkg::OFF_RANGE) begin
        for (int p = 1; p <= 8; p++) begin
          if (4'(p) >= rng_lo && 4'(p) <= rng_hi) begin
            if (hwdata[psf_pkg::RNG_EN_APPLY_BIT]) begin
              sec_en[p] <= hwdata[psf_pkg::RNG_EN_VAL_BIT];
            end
            if (hwdata[psf_pkg::RNG_MAX_APPLY_BIT] && max_ok(rng_max)) begin
              max_mac[p] <= rng_max;
            end
          end
        end
      end else if (max_i != 5'h1f && max_i != 5'h00 && max_ok(hwdata[9:0])) begin
        max_mac[max_i[3:0]] <= hwdata[9:0];
      end
    end
  end

  // ----------------------------------------
  // Link state and per-port MAC counts
  // ----------------------------------------
  assign link_rise = link_up & ~link_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_q <= 8'h00;
      flush_mask <= 8'h00;
    end else begin
      link_q <= link_up;
      flush_mask <= link_rise;
    end
  end

  // Port 0 and out-of-range ports are never secured
  assign req_secured = glob_en && req_port >= 4'h1 && req_port <= psf_pkg::LAST_PORT
                       && sec_en[req_port[3:0]];
  assign drop_now = req_valid && req_secured && !req_src_known && port_full[req_port];

  for (genvar g = 1; g <= 8; g++) begin : g_port
    assign learn_inc[g] = req_valid && !drop_now && !req_src_known && req_port == 4'(g);
    assign static_inc[g] = static_add_valid && static_port == 4'(g);
    assign age_dec[g] = age_valid && age_port == 4'(g);
    psf_mac_counter u_cnt (
      .hclk(hclk),
      .hresetn(hresetn),
      .inc_learn(learn_inc[g]),
      .inc_static(static_inc[g]),
      .dec_age(age_dec[g]),
      .clear(link_rise[g]),
      .max_mac(max_mac[g]),
      .full(port_full[g]),
      .count(mac_cnt[g])
    );
  end

  // ----------------------------------------
  // Filter decision, one cycle after the request
  // ----------------------------------------
  // Only ingress port decides; tags never reach this logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_valid <= 1'b0;
      dec_port <= 4'h0;
      dec_egress <= '0;
      dec_drop <= 1'b0;
      dec_learn <= 1'b0;
    end else begin
      dec_valid <= req_valid;
      dec_port <= req_port;
      dec_drop <= drop_now;
      dec_learn <= req_valid && !drop_now && !req_src_known;
      if (req_valid && !drop_now && req_port <= psf_pkg::LAST_PORT) begin
        dec_egress <= req_dst_mask & iso_mask[req_port] & ~port_bit(req_port);
      end else begin
        dec_egress <= '0;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  psf_pkg::psf_mask_t chk_mask;
  logic chk_secured;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chk_mask <= '0;
      chk_secured <= 1'b0;
    end else begin
      chk_mask <= (req_port <= psf_pkg::LAST_PORT) ? iso_mask[req_port] : '0;
      chk_secured <= req_secured;
    end
  end

  a_egress_in_set: assert property (@(posedge hclk) disable iff (!hresetn)
    dec_valid |-> (dec_egress & ~chk_mask) == 9'h000) else $error("egress outside set");
  a_cpu_cut_off: assert property (@(posedge hclk) disable iff (!hresetn)
    dec_valid && !chk_mask[0] |-> !dec_egress[0]) else $error("CPU reached from isolated port");
  a_one_way: assert property (@(posedge hclk) disable iff (!hresetn)
    req_valid && req_port <= 4'h8 && req_dst_mask == psf_pkg::ISO_ALL && !drop_now
    |=> dec_egress == (chk_mask & ~port_bit(dec_port))) else $error("egress not from own set");
  a_reset_state: assert property (@(posedge hclk)
    $rose(hresetn) |-> iso_mask[0] == 9'h1fe && iso_mask[8] == 9'h0ff && sec_en == 8'h00
    && max_mac[1] == 10'h005) else $error("bad reset configuration");
  a_global_off: assert property (@(posedge hclk) disable iff (!hresetn)
    dec_valid && !chk_secured |-> !dec_drop) else $error("drop while security off");
  a_limit_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    req_valid && req_secured && !req_src_known && mac_cnt[req_port] >= max_mac[req_port]
    |=> dec_drop && dec_egress == 9'h000) else $error("new MAC passed at limit");
  a_max_range: assert property (@(posedge hclk) disable iff (!hresetn)
    max_mac[3] >= 10'h001 && max_mac[3] <= 10'h3e8) else $error("maximum MAC out of range");
  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  a_flush_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    link_up[1] && !link_q[1] |=> flush_mask[1] ##1 !flush_mask[1] || link_rise[1])
    else $error("flush pulse wrong");

  c_drop: cover property (@(posedge hclk) disable iff (!hresetn) dec_drop);
  c_learn: cover property (@(posedge hclk) disable iff (!hresetn) dec_learn ##1 dec_learn);
  c_cpu_blocked: cover property (@(posedge hclk) disable iff (!hresetn) dec_valid && !chk_mask[0]);
  c_flush: cover property (@(posedge hclk) disable iff (!hresetn) |flush_mask);
endmodule : psf_filter
`default_nettype wire

// file: psf_port_model.sv
/*
  Model of the switch side: forwarding engine lookups, address table events and port links.
  Assumes the filter samples every request on the rising edge of hclk.
*/
`timescale 1ns/10ps
`default_nettype none
module psf_port_model (
  // Clock
  input wire logic hclk,
  // Lookup request
  output logic req_valid,
  output logic [3:0] req_port,
  output logic req_src_known,
  output psf_pkg::psf_mask_t req_dst_mask,
  // Filter decision
  input wire logic dec_valid,
  input wire logic [3:0] dec_port,
  input wire psf_pkg::psf_mask_t dec_egress,
  input wire logic dec_drop,
  input wire logic dec_learn,
  // Address table events and links
  output logic static_add_valid,
  output logic [3:0] static_port,
  output logic age_valid,
  output logic [3:0] age_port,
  output logic [8:1] link_up
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    req_valid = 1'b0;
    req_port = 4'h0;
    req_src_known = 1'b0;
    req_dst_mask = 9'h000;
    static_add_valid = 1'b0;
    static_port = 4'h0;
    age_valid = 1'b0;
    age_port = 4'h0;
    link_up = 8'h00;
  end
  // ----------------------------------------
  // Requests
  // ----------------------------------------
  // The known flag and destination mask are scrambled once idle so a stale value is never mistaken for a live one; req_port is held
  task automatic lookup(input logic [3:0] p, input logic k, input psf_pkg::psf_mask_t m, output logic [31:0] r);
    @(posedge hclk);
    req_valid <= 1'b1;
    req_port <= p;
    req_src_known <= k;
    req_dst_mask <= m;
    @(posedge hclk);
    req_valid <= 1'b0;
    req_src_known <= ~k;
    req_dst_mask <= ~m;
    #1;
    r = {16'h0000, dec_valid, dec_drop, dec_learn, dec_port, dec_egress};
  endtask : lookup
  task automatic table_event(input logic st, input logic [3:0] p);
    @(posedge hclk);
    if (st) begin
      static_add_valid <= 1'b1;
      static_port <= p;
    end else begin
      age_valid <= 1'b1;
      age_port <= p;
    end
    @(posedge hclk);
    static_add_valid <= 1'b0;
    age_valid <= 1'b0;
  endtask : table_event
  task automatic link_rise(input int p);
    @(posedge hclk);
    link_up[p] <= 1'b1;
  endtask : link_rise
endmodule : psf_port_model
`default_nettype wire

// file: testbench.sv
/*
  Self-checking bench for the port filter: AHB-Lite register tasks and lookup sequences.
  Assumes one slave on the bus, so hready is the filter's own hreadyout.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic req_valid, req_src_known, dec_valid, dec_drop, dec_learn, static_add_valid, age_valid;
  logic [3:0] req_port, dec_port, static_port, age_port;
  psf_pkg::psf_mask_t req_dst_mask, dec_egress;
  logic [8:1] link_up, flush_mask;
  int failures, checks_done, n;
  localparam logic [7:0] MAX3 = 8'h6c;
  assign hready = hreadyout;
  initial hclk = 1'b0;
  always #12.5 hclk = ~hclk;
  psf_filter u_psf_filter (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .req_valid(req_valid), .req_port(req_port), .req_src_known(req_src_known),
    .req_dst_mask(req_dst_mask), .dec_valid(dec_valid), .dec_port(dec_port), .dec_egress(dec_egress),
    .dec_drop(dec_drop), .dec_learn(dec_learn), .static_add_valid(static_add_valid),
    .static_port(static_port), .age_valid(age_valid), .age_port(age_port), .link_up(link_up),
    .flush_mask(flush_mask));
  psf_port_model u_psf_port_model (.hclk(hclk), .req_valid(req_valid), .req_port(req_port),
    .req_src_known(req_src_known), .req_dst_mask(req_dst_mask), .dec_valid(dec_valid), .dec_port(dec_port),
    .dec_egress(dec_egress), .dec_drop(dec_drop), .dec_learn(dec_learn), .static_add_valid(static_add_valid),
    .static_port(static_port), .age_valid(age_valid), .age_port(age_port), .link_up(link_up));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Ready is read just after the edge, before the registered outputs move
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, v);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000, v);
    chk(v, exp);
  endtask : rchk
  task automatic lk(input logic [3:0] p, input logic k, input logic [8:0] m, input logic [31:0] exp);
    u_psf_port_model.lookup(p, k, m, v);
    chk(v, exp);
  endtask : lk
  function automatic logic [31:0] dx(input logic dr, input logic ln, input logic [3:0] p, input logic [8:0] e);
    dx = {16'h0000, 1'b1, dr, ln, p, e};
  endfunction : dx
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // Tests need well under 2000 cycles; ten times that leaves room for slow answers
  initial begin
    #(25 * 20000);
    failures++;
    conclude();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    failures = 0;
    checks_done = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(psf_pkg::OFF_CTRL, 32'h00000000);
    rchk(psf_pkg::OFF_SEC_EN, 32'h00000000);
    for (int p = 0; p < 9; p++) begin
      rchk(psf_pkg::OFF_ISO_BASE + 8'(4 * p), {23'h000000, psf_pkg::ISO_ALL & ~(9'h001 << p)});
    end
    for (int p = 1; p < 9; p++) begin
      rchk(psf_pkg::OFF_MAX_BASE + 8'(4 * p), 32'h00000005);
    end
    rchk(8'hfc, 32'h00000000);
    rchk(psf_pkg::OFF_RANGE, 32'h00000000);
    $display("test reset values done");
    wr(8'h24, 32'h00000004);
    lk(4'h1, 1'b1, 9'h1ff, dx(1'b0, 1'b0, 4'h1, 9'h004));
    lk(4'h2, 1'b1, 9'h1ff, dx(1'b0, 1'b0, 4'h2, 9'h1fb));
    wr(8'h28, 32'h00000001);
    lk(4'h2, 1'b1, 9'h1ff, dx(1'b0, 1'b0, 4'h2, 9'h001));
    lk(4'h1, 1'b1, 9'h0f6, dx(1'b0, 1'b0, 4'h1, 9'h004));
    lk(4'h0, 1'b1, 9'h1ff, dx(1'b0, 1'b0, 4'h0, 9'h1fe));
    lk(4'h9, 1'b1, 9'h1ff, dx(1'b0, 1'b0, 4'h9, 9'h000));
    $display("test isolation done");
    wr(psf_pkg::OFF_RANGE, 32'h04020343);
    rchk(psf_pkg::OFF_SEC_EN, 32'h00000018);
    rchk(8'h74, 32'h00000005);
    rchk(MAX3, 32'h00000002);
    wr(MAX3, 32'h00000000);
    wr(MAX3, 32'h000003e9);
    rchk(MAX3, 32'h00000002);
    wr(MAX3, 32'h000003e8);
    rchk(MAX3, 32'h000003e8);
    wr(MAX3, 32'h00000002);
    $display("test configuration done");
    repeat (3) lk(4'h3, 1'b0, 9'h1ff, dx(1'b0, 1'b1, 4'h3, 9'h1f7));
    wr(psf_pkg::OFF_CTRL, 32'h00000001);
    rchk(psf_pkg::OFF_CTRL, 32'h00000001);
    lk(4'h3, 1'b0, 9'h1ff, dx(1'b1, 1'b0, 4'h3, 9'h000));
    lk(4'h3, 1'b1, 9'h1ff, dx(1'b0, 1'b0, 4'h3, 9'h1f7));
    rchk(MAX3, 32'h00030002);
    rchk(psf_pkg::OFF_FULL, 32'h00000008);
    repeat (2) u_psf_port_model.table_event(1'b0, 4'h3);
    lk(4'h3, 1'b0, 9'h1ff, dx(1'b0, 1'b1, 4'h3, 9'h1f7));
    lk(4'h3, 1'b0, 9'h1ff, dx(1'b1, 1'b0, 4'h3, 9'h000));
    u_psf_port_model.link_rise(3);
    n = 0;
    repeat (4) begin
      @(posedge hclk);
      #1;
      if (flush_mask === 8'h04) n++;
      else if (flush_mask !== 8'h00) n += 10;
    end
    chk(32'(n), 32'h00000001);
    rchk(MAX3, 32'h00000002);
    repeat (2) u_psf_port_model.table_event(1'b1, 4'h3);
    lk(4'h3, 1'b0, 9'h1ff, dx(1'b1, 1'b0, 4'h3, 9'h000));
    lk(4'h5, 1'b0, 9'h1ff, dx(1'b0, 1'b1, 4'h5, 9'h1df));
    wr(psf_pkg::OFF_CTRL, 32'h00000000);
    lk(4'h3, 1'b0, 9'h1ff, dx(1'b0, 1'b1, 4'h3, 9'h1f7));
    chk({31'h00000000, hresp}, 32'h00000000);
    wr(psf_pkg::OFF_RANGE, 32'h00000233);
    rchk(psf_pkg::OFF_SEC_EN, 32'h00000010);
    wr(psf_pkg::OFF_SEC_EN, 32'h00000041);
    rchk(psf_pkg::OFF_SEC_EN, 32'h00000040);
    $display("test mac limit done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
